//--- shared/qbsp_pkg.sv
// shared constants and carriers for the burst-of-four sram port
package qbsp_pkg;
  // data organisation: 18-bit variant; 36-bit variant uses DATA_W 36, ADDR_W 19
  localparam int DATA_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = DATA_W / LANE_W;
  localparam int ADDR_W     = 20;
  localparam int BURST_LEN  = 4;
  localparam int BEAT_W     = 2;
  localparam int WORD_AW    = ADDR_W + BEAT_W;
  localparam int MEM_WORDS  = 4194304;
  localparam int FIFO_DEPTH = 4;

  // timing: both-high time on the output clocks that selects single clock mode
  localparam int SYS_CLK_MHZ    = 40;
  localparam int SINGLE_DET_NS  = 400;
  localparam int SINGLE_DET_CYC = (SINGLE_DET_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SDET_W         = 5;

  // read side sequencing
  typedef enum logic [2:0] {
    RD_IDLE       = 3'b000,
    RD_WAIT_KN    = 3'b001,
    RD_WAIT_FIRST = 3'b010,
    RD_STREAM     = 3'b011,
    RD_DRAIN      = 3'b100
  } qbsp_rd_state_e;

  // every pin the memory controller drives
  typedef struct packed {
    logic              main_clk;
    logic              main_clk_n;
    logic              out_clk;
    logic              out_clk_n;
    logic              rd_sel_n;
    logic              wr_sel_n;
    logic              dll_off_n;
    logic [ADDR_W-1:0] addr_in;
    logic [LANES-1:0]  byte_wr_n;
    logic [DATA_W-1:0] wdata;
  } qbsp_pins_s;

  // read port pins driven back to the controller
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              rdata_oe_n;
    logic              echo_clk;
    logic              echo_clk_n;
  } qbsp_rd_s;
endpackage

//--- src/qbsp_fifo.sv
// small valid/ready fifo between array fetch and read data launch
`timescale 1ns/1ps
`default_nettype none
module qbsp_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("qbsp_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [PW:0]  wp_q;
  logic [PW:0]  rp_q;
  logic         push;
  logic         pop;

  // extra pointer bit separates full from empty
  assign in_ready  = (wp_q ^ rp_q) != {1'b1, {PW{1'b0}}};
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[PW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q[PW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

//--- src/qbsp_mem.sv
// word array with per-lane write enables and registered read
`timescale 1ns/1ps
`default_nettype none
module qbsp_mem #(
  parameter int DW    = 18,
  parameter int LW    = 9,
  parameter int AW    = 22,
  parameter int WORDS = 4194304
) (
  // clock
  input  wire logic             clk,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [DW-1:0]    wr_data,
  input  wire logic [DW/LW-1:0] wr_lane_en,
  // read port
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic [DW-1:0]         rd_data
);
  if (DW % LW != 0 || WORDS > (1 << AW)) begin : g_chk
    $error("qbsp_mem lane width or depth does not fit");
  end

  logic [DW-1:0] arr_q [WORDS];

  // one lane per write enable bit
  always_ff @(posedge clk) begin
    for (int l = 0; l < DW / LW; l++) begin
      if (wr_en && wr_lane_en[l]) arr_q[wr_addr][l*LW +: LW] <= wr_data[l*LW +: LW];
    end
  end

  // read data comes out of a register
  always_ff @(posedge clk) begin
    if (rd_en) rd_data <= arr_q[rd_addr];
  end
endmodule
`default_nettype wire

//--- src/qbsp_top.sv
// burst-of-four sram port with separate ddr read and write data paths
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - array holds 4,194,304 words of 18 bits, or 2,097,152 of 36.
// - write data on both input clock edges, read data on both output edges.
// - read and write addresses share one bus, taken on main_clk rises.
// - write data and controls are sampled against the input clock pair.
// - read data timed by output clocks, or input clocks when both held high.
// - complementary echo clocks move with the read data.
// - every burst is four sequential words over two bus cycles.
// - requests that would cut into a running burst are dropped.
// - byte_wr_n lanes gate nine-bit slices of each write word.
// - read starts when rd_sel_n low at main_clk rise; address captured there.
// - each read returns four words of the device width.
// - first read word at out_clk_n after next main_clk_n, then every edge.
// - back-to-back reads give gap-free read data.
// - with no new read, finish burst then deselect at next main_clk rise.
// - deselected read port floats its data drivers on its own.
// - dll held off while dll_off_n is low.
// - write starts when wr_sel_n low at main_clk rise; address captured there.
// - write words come at next main_clk rise, then alternating edges; all kept.
// - a second read or write on the very next main_clk rise is ignored.
// - write data outside a write burst is discarded.
module qbsp_top
  import qbsp_pkg::*;
#(
  parameter int FIFO_D = qbsp_pkg::FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // controller-side pins
  input  wire qbsp_pkg::qbsp_pins_s pins,
  // read port pins
  output qbsp_pkg::qbsp_rd_s        rd_port,
  // dll status
  output logic                      dll_en
);
  import qbsp_pkg::*;

  if (FIFO_D < BURST_LEN || MEM_WORDS * DATA_W != 75497472) begin : g_chk
    $error("qbsp_top fifo shallower than a burst or array size wrong");
  end

  // reset release synchroniser
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_i_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_i_n = rst_s2_q;

  // pin synchronisers; third stage only for edge finding
  qbsp_pins_s s1_q;
  qbsp_pins_s s2_q;
  qbsp_pins_s s3_q;

  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // clock edges seen by the system clock
  logic main_rise;
  logic main_n_rise;
  logic out_rise;
  logic out_n_rise;
  logic sel_p_edge;
  logic sel_n_edge;
  logic single_q;

  assign main_rise   = s2_q.main_clk & ~s3_q.main_clk;
  assign main_n_rise = s2_q.main_clk_n & ~s3_q.main_clk_n;
  assign out_rise    = s2_q.out_clk & ~s3_q.out_clk;
  assign out_n_rise  = s2_q.out_clk_n & ~s3_q.out_clk_n;
  // output timing source follows the clock mode
  assign sel_p_edge  = single_q ? main_rise : out_rise;
  assign sel_n_edge  = single_q ? main_n_rise : out_n_rise;

  // single clock mode: out clocks held high longer than any running phase
  logic [SDET_W-1:0] sdet_q;

  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sdet_q   <= '0;
      single_q <= 1'b0;
    end else begin
      if (!(s2_q.out_clk && s2_q.out_clk_n)) begin
        sdet_q <= '0;
      end else if (sdet_q != SDET_W'(SINGLE_DET_CYC)) begin
        sdet_q <= sdet_q + 1'b1;
      end
      single_q <= sdet_q == SDET_W'(SINGLE_DET_CYC);
    end
  end

  // dll enable follows its pin
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      dll_en <= 1'b0;
    end else begin
      dll_en <= s2_q.dll_off_n;
    end
  end

  // ---- read command capture
  logic              rd_take;
  logic              rd_last_q;
  logic              hold_v_q;
  logic [ADDR_W-1:0] hold_addr_q;
  logic              hold_load;

  // a read on the edge right after an accepted one is dropped
  assign rd_take = main_rise & ~s2_q.rd_sel_n & ~rd_last_q;

  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rd_last_q   <= 1'b0;
      hold_v_q    <= 1'b0;
      hold_addr_q <= '0;
    end else begin
      if (main_rise) rd_last_q <= rd_take;
      // a new capture wins over the fetcher taking the old one
      if (rd_take) begin
        hold_v_q    <= 1'b1;
        hold_addr_q <= s2_q.addr_in;
      end else if (hold_load) begin
        hold_v_q <= 1'b0;
      end
    end
  end

  // ---- array fetch into the fifo, one word in flight
  logic               f_act_q;
  logic [WORD_AW-1:0] f_addr_q;
  logic [2:0]         f_left_q;
  logic               f_fly_q;
  logic               mem_rd_en;
  logic [DATA_W-1:0]  mem_rd_data;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_pop;
  logic [DATA_W-1:0]  fifo_out_data;

  assign hold_load = hold_v_q & ~f_act_q;
  // fifo back-pressure stalls the fetcher
  assign mem_rd_en = f_act_q & (f_left_q != 3'd0) & ~f_fly_q & fifo_in_ready;

  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      f_act_q  <= 1'b0;
      f_addr_q <= '0;
      f_left_q <= '0;
      f_fly_q  <= 1'b0;
    end else begin
      f_fly_q <= mem_rd_en;
      if (hold_load) begin
        f_act_q  <= 1'b1;
        f_addr_q <= {hold_addr_q, {BEAT_W{1'b0}}};
        f_left_q <= 3'(BURST_LEN);
      end else if (mem_rd_en) begin
        f_addr_q <= f_addr_q + 1'b1;
        f_left_q <= f_left_q - 1'b1;
      end else if (f_act_q && f_left_q == 3'd0 && !f_fly_q) begin
        f_act_q <= 1'b0;
      end
    end
  end

  // ---- write capture and beats
  logic              wr_take;
  logic              wr_last_q;
  logic              arm_v_q;
  logic [ADDR_W-1:0] arm_addr_q;
  logic              w_act_q;
  logic [BEAT_W-1:0] w_beat_q;
  logic [ADDR_W-1:0] w_base_q;
  logic              w_start;
  logic              w_next;
  logic              mem_we;
  logic [WORD_AW-1:0] mem_waddr;

  assign wr_take = main_rise & ~s2_q.wr_sel_n & ~wr_last_q;
  assign w_start = main_rise & arm_v_q;
  assign w_next  = (main_rise | main_n_rise) & w_act_q & ~w_start;

  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      wr_last_q  <= 1'b0;
      arm_v_q    <= 1'b0;
      arm_addr_q <= '0;
      w_act_q    <= 1'b0;
      w_beat_q   <= '0;
      w_base_q   <= '0;
    end else begin
      if (main_rise) begin
        wr_last_q <= wr_take;
        arm_v_q   <= wr_take;
      end
      if (wr_take) arm_addr_q <= s2_q.addr_in;
      // first word at the next main_clk rise, then every input edge
      if (w_start) begin
        w_act_q  <= 1'b1;
        w_base_q <= arm_addr_q;
        w_beat_q <= BEAT_W'(1);
      end else if (w_next) begin
        w_beat_q <= w_beat_q + 1'b1;
        if (w_beat_q == BEAT_W'(BURST_LEN - 1)) w_act_q <= 1'b0;
      end
    end
  end

  // write only on burst beats; stray data is dropped
  assign mem_we    = w_start | w_next;
  assign mem_waddr = w_start ? {arm_addr_q, {BEAT_W{1'b0}}} : {w_base_q, w_beat_q};

  qbsp_mem #(
    .DW    (DATA_W),
    .LW    (LANE_W),
    .AW    (WORD_AW),
    .WORDS (MEM_WORDS)
  ) u_mem (
    .clk        (sys_clk),
    .wr_en      (mem_we),
    .wr_addr    (mem_waddr),
    .wr_data    (s2_q.wdata),
    .wr_lane_en (~s2_q.byte_wr_n),
    .rd_en      (mem_rd_en),
    .rd_addr    (f_addr_q),
    .rd_data    (mem_rd_data)
  );

  qbsp_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_i_n),
    .in_valid  (f_fly_q),
    .in_ready  (fifo_in_ready),
    .in_data   (mem_rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ---- read data launch
  qbsp_rd_state_e    rst_q;
  logic [1:0]        rd_pend_q;
  logic [BEAT_W-1:0] o_beat_q;
  logic              launch;
  logic              burst_end;
  logic [DATA_W-1:0] rdata_q;
  logic              oe_n_q;
  logic              echo_q;
  logic              echo_n_q;

  // once streaming, every output edge carries a word
  assign launch    = ((rst_q == RD_WAIT_FIRST) & sel_n_edge) |
                     ((rst_q == RD_STREAM) & (sel_p_edge | sel_n_edge));
  assign burst_end = launch & (o_beat_q == BEAT_W'(BURST_LEN - 1));
  // an empty fifo here would mean a late fetch; the last word is repeated
  assign fifo_pop  = launch & fifo_out_valid;

  // bursts captured but not fully sent
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rd_pend_q <= '0;
    end else begin
      rd_pend_q <= rd_pend_q + {1'b0, rd_take} - {1'b0, burst_end};
    end
  end

  // launch sequencer
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rst_q    <= RD_IDLE;
      o_beat_q <= '0;
    end else begin
      if (launch) o_beat_q <= o_beat_q + 1'b1;
      case (rst_q)
        RD_IDLE: begin
          if (rd_pend_q != 2'd0) rst_q <= RD_WAIT_KN;
        end
        RD_WAIT_KN: begin
          if (main_n_rise) rst_q <= RD_WAIT_FIRST;
        end
        RD_WAIT_FIRST: begin
          if (launch) rst_q <= RD_STREAM;
        end
        RD_STREAM: begin
          // a queued burst continues without a gap
          if (burst_end) rst_q <= (rd_pend_q > 2'd1) ? RD_STREAM : RD_DRAIN;
        end
        RD_DRAIN: begin
          if (main_rise) rst_q <= RD_IDLE;
        end
        default: rst_q <= RD_IDLE;
      endcase
    end
  end

  // read data pins and drivers
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rdata_q <= '0;
      oe_n_q  <= 1'b1;
    end else begin
      if (fifo_pop) rdata_q <= fifo_out_data;
      if (launch) begin
        oe_n_q <= 1'b0;
      end else if (rst_q == RD_DRAIN && main_rise) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  // echo clocks sampled from the same stage that times the data
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      echo_q   <= 1'b0;
      echo_n_q <= 1'b1;
    end else begin
      echo_q   <= single_q ? s2_q.main_clk : s2_q.out_clk;
      echo_n_q <= single_q ? s2_q.main_clk_n : s2_q.out_clk_n;
    end
  end

  assign rd_port.rdata      = rdata_q;
  assign rd_port.rdata_oe_n = oe_n_q;
  assign rd_port.echo_clk   = echo_q;
  assign rd_port.echo_clk_n = echo_n_q;
endmodule
`default_nettype wire

//--- testbench/qbsp_ctrl_model.sv
// memory controller model: link clocks, commands and write beats
`timescale 1ns/1ps
`default_nettype none
module qbsp_ctrl_model
  import qbsp_pkg::*;
(
  // sampling clock of the device
  input  wire logic           sys_clk,
  // mode and dll control from the bench
  input  wire logic           run,
  input  wire logic           single,
  input  wire logic           dll_on,
  // pins toward the device
  output qbsp_pkg::qbsp_pins_s pins
);
  import qbsp_pkg::*;
  int ph = 0;

  // idle pins: selects off, lanes masked
  initial begin
    pins = '0;
    pins.rd_sel_n = 1'b1;
    pins.wr_sel_n = 1'b1;
    pins.byte_wr_n = '1;
  end

  // eight sys cycles per link period; output pair a quarter late
  always @(negedge sys_clk) begin
    if (run) ph = (ph + 1) % 8;
    pins.main_clk = run && ph < 4;
    pins.main_clk_n = run && ph >= 4;
    pins.out_clk = single || (run && ph inside {[2:5]});
    pins.out_clk_n = single || (run && !(ph inside {[2:5]}));
    pins.dll_off_n = dll_on;
  end

  // returns one ns after the falling edge where the phase is reached
  task automatic wait_ph(input int p);
    do begin
      @(negedge sys_clk);
      #1;
    end while (ph != p);
  endtask

  // select held across one main_clk rise; released address flips
  task automatic read_cmd(input logic [ADDR_W-1:0] a);
    wait_ph(6);
    pins.rd_sel_n = 1'b0;
    pins.addr_in = a;
    wait_ph(2);
    pins.rd_sel_n = 1'b1;
    pins.addr_in = ~a;
  endtask

  // command, then four beats on alternating input clock rises
  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [4*DATA_W-1:0] d,
                             input logic [4*LANES-1:0] be);
    wait_ph(6);
    pins.wr_sel_n = 1'b0;
    pins.addr_in = a;
    wait_ph(2);
    pins.wr_sel_n = 1'b1;
    pins.addr_in = ~a;
    for (int i = 0; i < 4; i++) begin
      wait_ph(i % 2 ? 2 : 6);
      pins.wdata = d[i*DATA_W +: DATA_W];
      pins.byte_wr_n = be[i*LANES +: LANES];
    end
    // stray data with lanes open must still be dropped by the device
    wait_ph(6);
    pins.wdata = ~pins.wdata;
    pins.byte_wr_n = '0;
  endtask
endmodule
`default_nettype wire

//--- testbench/qbsp_checker.sv
// concurrent checks on the sram port pins
`timescale 1ns/1ps
`default_nettype none
module qbsp_checker
  import qbsp_pkg::*;
(
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  // watched ports
  input wire qbsp_pkg::qbsp_pins_s pins,
  input wire qbsp_pkg::qbsp_rd_s   rd_port,
  input wire logic                 dll_en
);
  import qbsp_pkg::*;
  logic [3:0] age_q;
  logic [4:0] hi_q;
  logic [5:0] idle_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // cycles since reset release; early ones still see the internal reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  end
  // cycles with both output clocks high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hi_q <= 5'h00;
    else if (!(pins.out_clk && pins.out_clk_n)) hi_q <= 5'h00;
    else if (hi_q != 5'h1F) hi_q <= hi_q + 5'h01;
  end
  // cycles since the read select was last low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) idle_q <= 6'h3F;
    else if (!pins.rd_sel_n) idle_q <= 6'h00;
    else if (idle_q != 6'h3F) idle_q <= idle_q + 6'h01;
  end

  sequence s_drive_hold;
    (!rd_port.rdata_oe_n)[*8];
  endsequence
  property p_oe_burst;
    $fell(rd_port.rdata_oe_n) |=> s_drive_hold;
  endproperty
  property p_oe_needs_read;
    $fell(rd_port.rdata_oe_n) |-> idle_q <= 6'h18;
  endproperty
  property p_rd_float;
    idle_q == 6'h3F |-> rd_port.rdata_oe_n;
  endproperty
  property p_data_hold;
    age_q == 4'hF && !rd_port.rdata_oe_n && !$past(rd_port.rdata_oe_n)
      && $stable(rd_port.echo_clk) |-> $stable(rd_port.rdata);
  endproperty
  property p_echo_pair;
    (age_q == 4'hF && pins.out_clk != pins.out_clk_n)[*4] |->
      rd_port.echo_clk == $past(pins.out_clk, 3) && rd_port.echo_clk_n == $past(pins.out_clk_n, 3);
  endproperty
  property p_echo_single;
    hi_q == 5'h1F |->
      rd_port.echo_clk == $past(pins.main_clk, 3) && rd_port.echo_clk_n == $past(pins.main_clk_n, 3);
  endproperty
  property p_dll_on;
    (age_q == 4'hF && pins.dll_off_n)[*8] |-> dll_en;
  endproperty
  property p_dll_off;
    (age_q == 4'hF && !pins.dll_off_n)[*8] |-> !dll_en;
  endproperty

  a_oe_burst: assert property (p_oe_burst) else $error("read burst cut short");
  a_oe_needs_read: assert property (p_oe_needs_read) else $error("drive without read");
  a_rd_float: assert property (p_rd_float) else $error("read drivers left on");
  a_data_hold: assert property (p_data_hold) else $error("read data moved off edge");
  a_echo_pair: assert property (p_echo_pair) else $error("echo off output pair");
  a_echo_single: assert property (p_echo_single) else $error("echo off input pair");
  a_dll_on: assert property (p_dll_on) else $error("dll not running");
  a_dll_off: assert property (p_dll_off) else $error("dll not stopped");
endmodule
bind qbsp_top qbsp_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins),
                                  .rd_port(rd_port), .dll_en(dll_en));
`default_nettype wire

//--- testbench/qbsp_top_tb.sv
// self-checking bench for the burst-of-four sram port
`timescale 1ns/1ps
`default_nettype none
module qbsp_top_tb;
  import qbsp_pkg::*;
  localparam int LIMIT = 20000;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              run = 1'b0;
  logic              single = 1'b0;
  logic              dll_on = 1'b1;
  qbsp_pins_s        pins;
  qbsp_rd_s          rd_port;
  logic              dll_en;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cycles = 0;
  int                oe_rises = 0;
  int                win_n = 0;
  logic              last_echo = 1'b0;
  logic              last_oe = 1'b1;
  logic [DATA_W-1:0] got_q[$];
  logic [DATA_W-1:0] ref_mem[int];

  always #12.5 sys_clk = ~sys_clk;

  qbsp_ctrl_model u_ctrl (.sys_clk(sys_clk), .run(run), .single(single), .dll_on(dll_on),
                          .pins(pins));
  qbsp_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .rd_port(rd_port),
                  .dll_en(dll_en));

  // a word is taken at every echo edge while the drivers are on
  always @(negedge sys_clk) begin
    if (rd_port.rdata_oe_n === 1'b0 && rd_port.echo_clk !== last_echo) begin
      got_q.push_back(rd_port.rdata);
      win_n++;
    end
    // drivers stay on through one more echo edge until deselect; it repeats the last word
    if (rd_port.rdata_oe_n === 1'b1 && last_oe === 1'b0) begin
      oe_rises++;
      if (win_n % 4 == 1 && got_q.size() > 0) void'(got_q.pop_back());
      win_n = 0;
    end
    last_echo = rd_port.echo_clk;
    last_oe = rd_port.rdata_oe_n;
  end
  // hang guard
  always @(negedge sys_clk) if (++cycles == LIMIT) begin
    error_cnt++;
    summarize();
  end

  task automatic summarize();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_w(input string what, input logic [DATA_W-1:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_i(input string what, input int exp, got);
    n_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  // write a group and fold the unmasked lanes into the reference
  task automatic put(input int g, input logic [4*DATA_W-1:0] d, input logic [4*LANES-1:0] be);
    u_ctrl.write_burst(ADDR_W'(g), d, be);
    for (int i = 0; i < 4; i++) begin
      if (!ref_mem.exists(g*4+i)) ref_mem[g*4+i] = 'x;
      for (int l = 0; l < LANES; l++)
        if (!be[i*LANES+l]) ref_mem[g*4+i][l*LANE_W +: LANE_W] = d[i*DATA_W+l*LANE_W +: LANE_W];
    end
  endtask
  // wait for n words, then a quiet spell so extra words would show
  task automatic collect(input int n);
    int k;
    k = 0;
    while (got_q.size() < n && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (40) @(negedge sys_clk);
    chk_i("word count", n, got_q.size());
  endtask
  task automatic expect_group(input int g);
    for (int i = 0; i < 4; i++)
      chk_w("read word", ref_mem[g*4+i], got_q.size() ? got_q.pop_front() : 'x);
  endtask

  task automatic t_write_read(input int g, input logic [4*DATA_W-1:0] d);
    got_q.delete();
    put(g, d, '0);
    u_ctrl.read_cmd(ADDR_W'(g));
    collect(4);
    expect_group(g);
    chk_w("drivers off", DATA_W'(1), DATA_W'(rd_port.rdata_oe_n));
  endtask
  task automatic t_lanes(input int g);
    got_q.delete();
    put(g, {4{18'h3FFFF}}, 8'h39);
    u_ctrl.read_cmd(ADDR_W'(g));
    collect(4);
    expect_group(g);
  endtask
  task automatic t_stream(input int a, input int b);
    int r;
    got_q.delete();
    r = oe_rises;
    u_ctrl.read_cmd(ADDR_W'(a));
    u_ctrl.wait_ph(2);
    u_ctrl.read_cmd(ADDR_W'(b));
    collect(8);
    expect_group(a);
    expect_group(b);
    chk_i("drive windows", r + 1, oe_rises);
  endtask
  task automatic t_refused(input int a, input int b);
    got_q.delete();
    u_ctrl.read_cmd(ADDR_W'(a));
    u_ctrl.read_cmd(ADDR_W'(b));
    collect(4);
    expect_group(a);
  endtask
  task automatic t_dll();
    dll_on = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk_w("dll state", '0, DATA_W'(dll_en));
    dll_on = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk_w("dll state", DATA_W'(1), DATA_W'(dll_en));
  endtask
  task automatic start(input logic one_pair);
    rst_n = 1'b0;
    run = 1'b0;
    single = one_pair;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    run = 1'b1;
    repeat (40) @(negedge sys_clk);
  endtask

  initial begin
    start(1'b0);
    t_write_read(5, {18'h2AAAA, 18'h15555, 18'h3C3C3, 18'h00F0F});
    t_lanes(5);
    t_write_read(6, {18'h0A5C3, 18'h31E07, 18'h12345, 18'h3FEDC});
    t_stream(5, 6);
    t_refused(6, 5);
    t_dll();
    start(1'b1);
    t_write_read((1 << ADDR_W) - 1, {18'h1B2C3, 18'h2D4E5, 18'h06F71, 18'h38293});
    summarize();
  end
endmodule
`default_nettype wire
